// *** verilog/fsr_ctrl.sv ***
// Suspend/resume and write-enable latch control for a serial flash.
// Assumes the program/erase engine sits outside on clk_sys and reports busy.
`include "fsr_defines.svh"

module fsr_ctrl
    import fsr_pkg::*;
#(
    parameter int RESUME_LAT_CYC = `FSR_RESUME_LAT_NS * `FSR_CLK_MHZ / 1000
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic cs_b_pin,
    input wire logic sck_pin,
    input wire logic mosi_pin,
    input wire logic engine_busy,
    input wire logic engine_erase,
    input wire logic latch_clear,
    output logic write_latch_flag,
    output logic program_held_flag,
    output logic erase_held_flag,
    output logic busy,
    output logic resuming,
    output logic suspend_req,
    output logic resume_prog,
    output logic resume_erase,
    output logic exec_valid,
    output logic [7:0] exec_opcode,
    output logic cmd_reject
);
    localparam logic [`FSR_RCNT_W-1:0] LAT_LAST = `FSR_RCNT_W'(RESUME_LAT_CYC - 1);

    fsr_ctrl_t s_q;
    fsr_ctrl_t s_d;
    logic frame_end;
    logic op_ok;
    logic [7:0] opcode;
    logic allowed;
    logic needs_latch;
    logic take;

    fsr_spi_rx u_rx
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .cs_b_pin(cs_b_pin),
        .sck_pin(sck_pin),
        .mosi_pin(mosi_pin),
        .frame_end(frame_end),
        .op_ok(op_ok),
        .opcode(opcode)
    );

    fsr_cmd_gate u_gate
    (
        .opcode(opcode),
        .prog_held(s_q.pheld),
        .erase_held(s_q.eheld),
        .allowed(allowed),
        .needs_latch(needs_latch)
    );

    // Commands act only when the frame closes on a byte boundary
    assign take = frame_end && op_ok;

    always_comb
    begin
        s_d = s_q;
        s_d.suspend = 1'b0;
        s_d.resume_prog = 1'b0;
        s_d.resume_erase = 1'b0;
        s_d.exec = 1'b0;
        s_d.reject = 1'b0;
        if (s_q.resuming)
        begin
            if (s_q.rcnt == LAT_LAST)
            begin
                s_d.resuming = 1'b0;
            end
            else
            begin
                s_d.rcnt = s_q.rcnt + `FSR_RCNT_W'(1);
            end
        end
        // Engine clear first, so a write enable in the same cycle wins
        if (latch_clear)
        begin
            s_d.wlatch = 1'b0;
        end
        if (take)
        begin
            if (!allowed)
            begin
                s_d.reject = 1'b1;
            end
            else
            begin
                case (opcode)
                    `FSR_OP_WREN:
                        s_d.wlatch = 1'b1;
                    `FSR_OP_WRDI:
                        s_d.wlatch = 1'b0;
                    `FSR_OP_SUSPEND:
                    begin
                        // A suspend during the resume window would lose the engine state
                        if (engine_busy && !s_q.resuming)
                        begin
                            s_d.suspend = 1'b1;
                            if (engine_erase)
                            begin
                                s_d.eheld = 1'b1;
                            end
                            else
                            begin
                                s_d.pheld = 1'b1;
                            end
                        end
                    end
                    `FSR_OP_RESUME:
                    begin
                        // No latch check here: resume must work with the latch clear
                        if (s_q.pheld)
                        begin
                            s_d.resume_prog = 1'b1;
                            s_d.pheld = 1'b0;
                            s_d.resuming = 1'b1;
                            s_d.rcnt = `FSR_RCNT_ZERO;
                        end
                        else if (s_q.eheld)
                        begin
                            s_d.resume_erase = 1'b1;
                            s_d.eheld = 1'b0;
                            s_d.resuming = 1'b1;
                            s_d.rcnt = `FSR_RCNT_ZERO;
                        end
                    end
                    `FSR_OP_RESET:
                    begin
                        // Reset abandons any suspended operation
                        s_d.pheld = 1'b0;
                        s_d.eheld = 1'b0;
                        s_d.exec = 1'b1;
                        s_d.exec_op = opcode;
                    end
                    default:
                    begin
                        if (needs_latch && !s_q.wlatch)
                        begin
                            s_d.reject = 1'b1;
                        end
                        else
                        begin
                            s_d.exec = 1'b1;
                            s_d.exec_op = opcode;
                        end
                    end
                endcase
            end
        end
        s_d.busy = engine_busy || s_d.resuming;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign write_latch_flag = s_q.wlatch;
    assign program_held_flag = s_q.pheld;
    assign erase_held_flag = s_q.eheld;
    assign busy = s_q.busy;
    assign resuming = s_q.resuming;
    assign suspend_req = s_q.suspend;
    assign resume_prog = s_q.resume_prog;
    assign resume_erase = s_q.resume_erase;
    assign exec_valid = s_q.exec;
    assign exec_opcode = s_q.exec_op;
    assign cmd_reject = s_q.reject;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    property p_reject_quiet;
        ce && take && (s_q.pheld || s_q.eheld) && opcode == `FSR_OP_BLOCK_ERASE && !latch_clear
        |=> cmd_reject && !exec_valid && $stable(write_latch_flag) && $stable(program_held_flag);
    endproperty
    a_reject_quiet: assert property (p_reject_quiet) else $error("erase in suspension not rejected");

    property p_prog_susp_wren;
        ce && take && s_q.pheld && opcode == `FSR_OP_WREN && !latch_clear
        |=> cmd_reject && $stable(write_latch_flag);
    endproperty
    a_prog_susp_wren: assert property (p_prog_susp_wren) else $error("latch write in program hold");

    property p_erase_susp_prog;
        ce && take && s_q.eheld && !s_q.pheld && s_q.wlatch && opcode == `FSR_OP_PROGRAM
        |=> exec_valid && exec_opcode == `FSR_OP_PROGRAM;
    endproperty
    a_erase_susp_prog: assert property (p_erase_susp_prog) else $error("program refused in erase hold");

    property p_bad_frame;
        ce && frame_end && !op_ok && !latch_clear
        |=> !resume_prog && !resume_erase && !suspend_req && $stable(write_latch_flag);
    endproperty
    a_bad_frame: assert property (p_bad_frame) else $error("action on a broken frame");

    property p_resume_prog;
        ce && take && opcode == `FSR_OP_RESUME && s_q.pheld
        |=> resume_prog && !program_held_flag && busy && resuming ##1 !resume_prog;
    endproperty
    a_resume_prog: assert property (p_resume_prog) else $error("program resume wrong");

    property p_resume_no_latch;
        ce && take && opcode == `FSR_OP_RESUME && !s_q.pheld && s_q.eheld && !s_q.wlatch
        |=> resume_erase && !erase_held_flag;
    endproperty
    a_resume_no_latch: assert property (p_resume_no_latch) else $error("resume needed the latch");

    property p_both_held;
        ce && take && opcode == `FSR_OP_RESUME && s_q.pheld && s_q.eheld
        |=> !resume_erase && erase_held_flag;
    endproperty
    a_both_held: assert property (p_both_held) else $error("erase resumed before program");

    property p_no_susp_resuming;
        ce && take && opcode == `FSR_OP_SUSPEND && s_q.resuming |=> !suspend_req;
    endproperty
    a_no_susp_resuming: assert property (p_no_susp_resuming) else $error("suspend taken while resuming");

    property p_latency;
        $rose(resuming) && RESUME_LAT_CYC > 8 |-> resuming [*8];
    endproperty
    a_latency: assert property (p_latency) else $error("resume window ended early");

    property p_wren;
        ce && take && opcode == `FSR_OP_WREN && allowed |=> write_latch_flag;
    endproperty
    a_wren: assert property (p_wren) else $error("write enable did not set latch");

    property p_wrdi;
        ce && take && opcode == `FSR_OP_WRDI && allowed |=> !write_latch_flag;
    endproperty
    a_wrdi: assert property (p_wrdi) else $error("write disable did not clear latch");

    property p_need_latch;
        ce && take && allowed && needs_latch && !s_q.wlatch |=> cmd_reject && !exec_valid;
    endproperty
    a_need_latch: assert property (p_need_latch) else $error("command ran without latch");

    property p_suspend;
        ce && take && allowed && opcode == `FSR_OP_SUSPEND && engine_busy && !engine_erase && !s_q.resuming
        |=> suspend_req && program_held_flag;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend did not hold program");

    c_suspend: cover property (suspend_req && erase_held_flag);
    c_both: cover property (program_held_flag && erase_held_flag);
    c_resume: cover property (resume_prog ##[1:1000] resume_erase);
    c_reject: cover property (cmd_reject && program_held_flag);
endmodule

// *** verilog/fsr_defines.svh ***
// Opcodes, timing and widths for the suspend/resume and write-latch control.
// Assumes one compilation unit; the guard keeps repeated inclusion harmless.
`ifndef FSR_DEFINES_SVH
`define FSR_DEFINES_SVH

`define FSR_OP_WREN 8'h06
`define FSR_OP_WRDI 8'h04
`define FSR_OP_SUSPEND 8'hB0
`define FSR_OP_RESUME 8'hD0
`define FSR_OP_CHIP_ERASE_A 8'h60
`define FSR_OP_CHIP_ERASE_B 8'hC7
`define FSR_OP_PROTECT 8'h36
`define FSR_OP_UNPROTECT 8'h39
`define FSR_OP_READ_ARRAY 8'h11
`define FSR_OP_PROGRAM 8'h12
`define FSR_OP_BLOCK_ERASE 8'h13
`define FSR_OP_READ_PROT 8'h14
`define FSR_OP_LOCKDOWN 8'h15
`define FSR_OP_FREEZE 8'h16
`define FSR_OP_READ_LOCK 8'h17
`define FSR_OP_PROG_OTP 8'h18
`define FSR_OP_READ_OTP 8'h19
`define FSR_OP_READ_STATUS 8'h1A
`define FSR_OP_WRITE_STATUS 8'h1B
`define FSR_OP_RESET 8'h1C
`define FSR_OP_READ_ID 8'h1D
`define FSR_OP_DEEP_PD 8'h1E
`define FSR_OP_RESUME_PD 8'h1F

`define FSR_BIT_LAST 3'h7
`define FSR_BIT_ZERO 3'h0
`define FSR_CLK_MHZ 250
`define FSR_RESUME_LAT_NS 40000
`define FSR_RCNT_W 16
`define FSR_RCNT_ZERO 16'h0000

`endif

// *** verilog/fsr_pkg.sv ***
// State types for the suspend/resume and write-latch control.
// Assumes the defines header sits beside it on the include path.
`include "fsr_defines.svh"
package fsr_pkg;
    typedef struct packed {
        logic cs_m;
        logic cs_s;
        logic cs_p;
        logic sck_m;
        logic sck_s;
        logic sck_p;
        logic mosi_m;
        logic mosi_s;
        logic [7:0] shift;
        logic [2:0] bitcnt;
        logic got_op;
        logic [7:0] opcode;
        logic frame_end;
        logic op_ok;
    } fsr_rx_t;

    typedef struct packed {
        logic wlatch;
        logic pheld;
        logic eheld;
        logic resuming;
        logic [`FSR_RCNT_W-1:0] rcnt;
        logic busy;
        logic suspend;
        logic resume_prog;
        logic resume_erase;
        logic exec;
        logic [7:0] exec_op;
        logic reject;
    } fsr_ctrl_t;
endpackage

// *** verilog/fsr_spi_rx.sv ***
// Serial command receiver: synchronises the pins and captures the opcode byte.
// Assumes SPI mode 0 or 3 and a serial clock well below clk_sys / 4.
`include "fsr_defines.svh"
module fsr_spi_rx
    import fsr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic cs_b_pin,
    input wire logic sck_pin,
    input wire logic mosi_pin,
    output logic frame_end,
    output logic op_ok,
    output logic [7:0] opcode
);
    fsr_rx_t s_q;
    fsr_rx_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.frame_end = 1'b0;
        s_d.cs_m = cs_b_pin;
        s_d.cs_s = s_q.cs_m;
        s_d.cs_p = s_q.cs_s;
        s_d.sck_m = sck_pin;
        s_d.sck_s = s_q.sck_m;
        s_d.sck_p = s_q.sck_s;
        s_d.mosi_m = mosi_pin;
        s_d.mosi_s = s_q.mosi_m;
        if (!s_q.cs_s && s_q.cs_p)
        begin
            s_d.bitcnt = `FSR_BIT_ZERO;
            s_d.got_op = 1'b0;
        end
        else if (!s_q.cs_s && s_q.sck_s && !s_q.sck_p)
        begin
            // Mosi runs through the same two stages, so it lines up with the edge
            s_d.shift = {s_q.shift[6:0], s_q.mosi_s};
            s_d.bitcnt = s_q.bitcnt + 3'h1;
            if (s_q.bitcnt == `FSR_BIT_LAST && !s_q.got_op)
            begin
                s_d.opcode = {s_q.shift[6:0], s_q.mosi_s};
                s_d.got_op = 1'b1;
            end
        end
        if (s_q.cs_s && !s_q.cs_p)
        begin
            s_d.frame_end = 1'b1;
            s_d.op_ok = s_q.got_op && (s_q.bitcnt == `FSR_BIT_ZERO);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '{cs_m: 1'b1, cs_s: 1'b1, cs_p: 1'b1, default: '0};
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign frame_end = s_q.frame_end;
    assign op_ok = s_q.op_ok;
    assign opcode = s_q.opcode;
endmodule

// *** verilog/fsr_cmd_gate.sv ***
// Combinational opcode classifier: suspension filter and write-latch need.
// Assumes the held flags come from registers on the same clock.
`include "fsr_defines.svh"
module fsr_cmd_gate
    import fsr_pkg::*;
(
    input wire logic [7:0] opcode,
    input wire logic prog_held,
    input wire logic erase_held,
    output logic allowed,
    output logic needs_latch
);
    always_comb
    begin
        allowed = 1'b0;
        needs_latch = 1'b0;
        unique case (opcode)
            `FSR_OP_READ_ARRAY, `FSR_OP_READ_PROT, `FSR_OP_READ_LOCK, `FSR_OP_READ_OTP,
            `FSR_OP_READ_STATUS, `FSR_OP_READ_ID, `FSR_OP_RESUME, `FSR_OP_RESET:
                allowed = 1'b1;
            `FSR_OP_PROGRAM:
            begin
                allowed = !prog_held;
                needs_latch = 1'b1;
            end
            `FSR_OP_SUSPEND, `FSR_OP_WREN, `FSR_OP_WRDI:
                allowed = !prog_held;
            `FSR_OP_BLOCK_ERASE, `FSR_OP_CHIP_ERASE_A, `FSR_OP_CHIP_ERASE_B, `FSR_OP_PROTECT,
            `FSR_OP_UNPROTECT, `FSR_OP_LOCKDOWN, `FSR_OP_FREEZE, `FSR_OP_PROG_OTP,
            `FSR_OP_WRITE_STATUS:
                needs_latch = 1'b1;
            default:
                allowed = 1'b0;
        endcase
        // Outside any suspension every opcode passes; unknown ones go downstream
        if (!prog_held && !erase_held)
        begin
            allowed = 1'b1;
        end
    end
endmodule

// *** test/fsr_host_model.sv ***
// Host side of the serial link: frames opcodes on chip select, serial clock and data.
// Assumes mode 0 (clock idles low) and a 32 ns serial clock period.
module fsr_host_model
(
    output logic cs_b,
    output logic sck,
    output logic mosi
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        cs_b = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end

    // Opcode leads, MSB first; the scenario picks the bit count, so odd frames are on purpose
    task automatic send(input logic [15:0] data, input int nbits);
        begin
            cs_b = 1'b0;
            for (int i = 0; i < nbits; i++)
            begin
                mosi = data[15 - i];
                #16;
                sck = 1'b1;
                #16;
                sck = 1'b0;
            end
            #16;
            cs_b = 1'b1;
            // Released line shows the inverse so a stale bit cannot pass for data
            mosi = ~mosi;
            #40;
        end
    endtask
endmodule

// *** test/flash_suspend_resume_wel_ctrl_test.sv ***
// Self-checking bench: host model frames commands, the bench plays the engine.
// Assumes the design asserts its own rules inline; pulses are caught by sticky monitors.
`include "fsr_defines.svh"
module flash_suspend_resume_wel_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;

    // Long enough to fit a whole suspend frame inside the resume window
    localparam int LAT = 200;
    logic clk_sys, rst_b, ce, engine_busy, engine_erase, latch_clear;
    logic cs_b, sck, mosi;
    logic wlf, phf, ehf, busy, resuming, suspend_req, resume_prog, resume_erase, exec_valid, cmd_reject;
    logic [7:0] exec_opcode;
    logic s_sus, s_rp, s_re, s_ex, s_rj;
    logic [7:0] ops [21];
    int fails, total_checks;

    fsr_host_model host (.cs_b(cs_b), .sck(sck), .mosi(mosi));

    fsr_ctrl #(.RESUME_LAT_CYC(LAT)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .cs_b_pin(cs_b), .sck_pin(sck), .mosi_pin(mosi),
        .engine_busy(engine_busy), .engine_erase(engine_erase), .latch_clear(latch_clear),
        .write_latch_flag(wlf), .program_held_flag(phf), .erase_held_flag(ehf), .busy(busy),
        .resuming(resuming), .suspend_req(suspend_req), .resume_prog(resume_prog),
        .resume_erase(resume_erase), .exec_valid(exec_valid), .exec_opcode(exec_opcode),
        .cmd_reject(cmd_reject));

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        if (suspend_req === 1'b1) s_sus <= 1'b1;
        if (resume_prog === 1'b1) s_rp <= 1'b1;
        if (resume_erase === 1'b1) s_re <= 1'b1;
        if (exec_valid === 1'b1) s_ex <= 1'b1;
        if (cmd_reject === 1'b1) s_rj <= 1'b1;
    end

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic eng(input logic b, input logic e);
        @(posedge clk_sys);
        #1;
        engine_busy = b;
        engine_erase = e;
    endtask

    // One frame; monitors are cleared first, so a pulse seen belongs to this command
    task automatic cmd(input logic [15:0] data, input int nbits);
        @(posedge clk_sys);
        #1;
        {s_sus, s_rp, s_re, s_ex, s_rj} = 5'h00;
        host.send(data, nbits);
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic pulses(input logic [7:0] exp);
        chk({3'h0, s_sus, s_rp, s_re, s_ex, s_rj}, exp);
    endtask

    task automatic flags(input logic [7:0] exp);
        chk({5'h00, wlf, phf, ehf}, exp);
    endtask

    initial
    begin
        #100000;
        fails++;
        summarize();
    end

    initial
    begin
        ops = '{8'h11, 8'h14, 8'h17, 8'h19, 8'h1A, 8'h1D, 8'h13, 8'h60, 8'hC7, 8'h12, 8'hB0,
                8'h06, 8'h04, 8'h36, 8'h39, 8'h15, 8'h16, 8'h18, 8'h1B, 8'h1E, 8'h1F};
        {s_sus, s_rp, s_re, s_ex, s_rj} = 5'h00;
        fails = 0;
        total_checks = 0;
        rst_b = 1'b0;
        ce = 1'b1;
        engine_busy = 1'b0;
        engine_erase = 1'b0;
        latch_clear = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        flags(8'h00);
        chk({6'h00, busy, resuming}, 8'h00);
        cmd({`FSR_OP_WREN, 8'h00}, 7);
        flags(8'h00);
        cmd({`FSR_OP_WREN, 8'h00}, 8);
        flags(8'h04);
        pulses(8'h00);
        cmd({`FSR_OP_WRDI, 8'h00}, 12);
        flags(8'h04);
        cmd({`FSR_OP_WRDI, 8'hFF}, 16);
        flags(8'h00);
        cmd({`FSR_OP_PROGRAM, 8'h00}, 8);
        pulses(8'h01);
        cmd({`FSR_OP_WREN, 8'h00}, 8);
        eng(1'b1, 1'b1);
        cmd({`FSR_OP_SUSPEND, 8'h00}, 8);
        pulses(8'h10);
        flags(8'h05);
        eng(1'b0, 1'b0);
        cmd({`FSR_OP_PROGRAM, 8'h00}, 8);
        pulses(8'h02);
        chk(exec_opcode, `FSR_OP_PROGRAM);
        eng(1'b1, 1'b0);
        cmd({`FSR_OP_SUSPEND, 8'h00}, 8);
        pulses(8'h10);
        flags(8'h07);
        eng(1'b0, 1'b0);
        // Both held: program-suspend limits; the first six are reads and pass through
        for (int i = 0; i < 21; i++)
        begin
            cmd({ops[i], 8'h00}, 8);
            pulses((i < 6) ? 8'h02 : 8'h01);
            flags(8'h07);
        end
        cmd({`FSR_OP_RESUME, 8'hA5}, 16);
        pulses(8'h08);
        flags(8'h05);
        chk({6'h00, busy, resuming}, 8'h03);
        eng(1'b1, 1'b0);
        cmd({`FSR_OP_SUSPEND, 8'h00}, 8);
        pulses(8'h00);
        flags(8'h05);
        for (int i = 0; i < LAT && resuming === 1'b1; i++)
            @(posedge clk_sys);
        #1;
        chk({7'h00, resuming}, 8'h00);
        eng(1'b0, 1'b0);
        // Clock enable low freezes the latch even against an engine clear
        ce = 1'b0;
        latch_clear = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        flags(8'h05);
        ce = 1'b1;
        @(posedge clk_sys);
        #1;
        latch_clear = 1'b0;
        @(posedge clk_sys);
        #1;
        flags(8'h01);
        cmd({`FSR_OP_RESUME, 8'h00}, 12);
        pulses(8'h00);
        flags(8'h01);
        cmd({`FSR_OP_RESUME, 8'h00}, 8);
        pulses(8'h04);
        flags(8'h00);
        chk({7'h00, busy}, 8'h01);
        // Poll the window closed, hold the erase again, then a reset drops the hold
        for (int i = 0; i < LAT && resuming === 1'b1; i++)
            @(posedge clk_sys);
        #1;
        chk({7'h00, resuming}, 8'h00);
        eng(1'b1, 1'b1);
        cmd({`FSR_OP_SUSPEND, 8'h00}, 8);
        pulses(8'h10);
        flags(8'h01);
        eng(1'b0, 1'b0);
        cmd({`FSR_OP_RESET, 8'h00}, 8);
        pulses(8'h02);
        flags(8'h00);
        chk(exec_opcode, `FSR_OP_RESET);
        summarize();
    end
endmodule
